// [test_usf_uart.sv]
// Self-checking bench for the serial port status flags against a remote line model.
`timescale 1ns/1ps
`default_nettype none
module test_usf_uart;
   logic        core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, rx_enable = 1'b1, tx_enable = 1'b1;
   logic        parity_enable_bit = 1'b0, parity_even = 1'b0, two_stop_bits = 1'b0;
   logic        status_rd = 1'b0, rx_buf_rd = 1'b0, tx_buf_wr = 1'b0, serial_in_pin;
   logic        serial_out_pin, rx_irq, tx_irq, got_v;
   logic [15:0] bit_period = 16'h0003;
   logic [7:0]  tx_wdata = 8'h00, serial_status_reg, rx_data_buffer, got, d, e;
   logic [7:0]  rxq[$], txq[$];
   int          fails = 0, check_count = 0;
   always #10 core_clk = ~core_clk;
   usf_uart dut (.*);
   usf_line_model #(.BT(4)) line (.*);
   task automatic end_of_test();
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      check_count++;
      if (g !== x) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic acc(input logic s, input logic r, input logic w, input logic [7:0] v);
      {status_rd, rx_buf_rd, tx_buf_wr, tx_wdata} = {s, r, w, v};
      tick();
      {status_rd, rx_buf_rd, tx_buf_wr} = 3'h0;
      tick();
   endtask
   task automatic wait_sr(input int b, input logic v);
      int i;
      for (i = 0; i < 300 && serial_status_reg[b] !== v; i++) tick();
      if (i == 300) begin
         chk("wait", {7'h0, v}, {7'h0, serial_status_reg[b]});
         end_of_test();
      end
   endtask
   task automatic snd(input logic [7:0] v, input logic bad, input logic ld);
      if (ld) rxq.push_back(v);
      line.send(v, bad);
      tick();
   endtask
   // Status read always precedes the buffer write, as the host must do.
   task automatic wrb(input logic [7:0] v);
      txq.push_back(v);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b0, 1'b1, v);
   endtask
   always @(posedge core_clk) begin
      if (rx_irq === 1'b1) chk("rx_data", rxq.size() ? rxq.pop_front() : 8'hXX, rx_data_buffer);
      if (got_v === 1'b1) chk("line_out", txq.size() ? txq.pop_front() : 8'hXX, got);
   end
   initial begin
      void'($urandom(54));
      repeat (10) @(posedge core_clk);
      #1 srst = 1'b0;
      tick();
      chk("status", 8'h0C, serial_status_reg);
      acc(1'b0, 1'b0, 1'b1, 8'h5A);
      chk("status", 8'h0C, serial_status_reg);
      // A frozen port must take neither the status read nor the write, so nothing is sent.
      clk_en = 1'b0;
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b0, 1'b1, 8'hA5);
      chk("status", 8'h0C, serial_status_reg);
      clk_en = 1'b1;
      for (int m = 0; m < 4; m++) begin
         {parity_enable_bit, two_stop_bits, parity_even} = {m[1:0], 1'($urandom)};
         wrb(8'($urandom));
         wait_sr(2, 1'b1);
         chk("status", 8'h04, serial_status_reg);
         wrb(8'($urandom));
         chk("status", 8'h00, serial_status_reg);
         wait_sr(3, 1'b1);
         chk("status", 8'h0C, serial_status_reg);
      end
      {parity_enable_bit, parity_even} = {1'b1, 1'($urandom)};
      d = 8'($urandom);
      e = 8'($urandom);
      snd(d, 1'b0, 1'b1);
      chk("status", 8'h1C, serial_status_reg);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h1C, serial_status_reg);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h0C, serial_status_reg);
      snd(e, 1'b1, 1'b1);
      chk("status", 8'h9C, serial_status_reg);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h0C, serial_status_reg);
      snd(d, 1'b0, 1'b1);
      snd(e, 1'b0, 1'b0);
      chk("status", 8'h3C, serial_status_reg);
      snd(~e, 1'b0, 1'b0);
      chk("buffer", d, rx_data_buffer);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h0C, serial_status_reg);
      parity_enable_bit = 1'b0;
      snd(e, 1'b0, 1'b1);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      snd(d, 1'b0, 1'b0);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h2C, serial_status_reg);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      chk("status", 8'h0C, serial_status_reg);
      chk("rx_left", 8'h00, 8'(rxq.size()));
      chk("tx_left", 8'h00, 8'(txq.size()));
      end_of_test();
   end
endmodule
`default_nettype wire

// [usf_bit_timer.v]
// Bit-period timer: pulses once every programmed period plus one enabled clocks.
`timescale 1ns/1ps
`default_nettype none
module usf_bit_timer #(
   parameter DIV_W = 16
) (
   input  wire             core_clk,
   input  wire             srst,
   input  wire             clk_en,
   input  wire             run,
   input  wire [DIV_W-1:0] half_start,
   input  wire [DIV_W-1:0] period,
   output reg              tick
);
   reg [DIV_W-1:0] cnt_reg;
   always @(posedge core_clk) begin
      if (srst) begin
         cnt_reg <= {DIV_W{1'b0}};
         tick    <= 1'b0;
      end else if (clk_en) begin
         tick <= 1'b0;
         if (!run) begin
            cnt_reg <= half_start;
         end else if (cnt_reg == {DIV_W{1'b0}}) begin
            cnt_reg <= period;
            tick    <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

// [usf_consts.vh]
// Constants for the serial-port status-flag block.
`ifndef USF_CONSTS_VH
`define USF_CONSTS_VH
`define USF_SR_PAR_ERR_BIT  7
`define USF_SR_FRM_ERR_BIT  6
`define USF_SR_OVR_ERR_BIT  5
`define USF_SR_RX_FULL_BIT  4
`define USF_SR_TX_DONE_BIT  3
`define USF_SR_TX_EMPTY_BIT 2
`define USF_SR_RESET      8'h0C
`define USF_TX_IDLE       2'h0
`define USF_TX_SHIFT      2'h1
`define USF_TX_STOP       2'h2
`define USF_RX_IDLE       2'h0
`define USF_RX_DATA       2'h1
`define USF_RX_PAR        2'h2
`define USF_RX_STOP       2'h3
`endif

// [usf_line_model.sv]
// Remote serial device: sends frames into the port and decodes what the port sends.
`timescale 1ns/1ps
`default_nettype none
module usf_line_model #(
   parameter BT = 4
) (
   input  wire logic       core_clk,
   input  wire logic       serial_out_pin,
   input  wire logic       parity_enable_bit,
   input  wire logic       parity_even,
   output var  logic       serial_in_pin,
   output var  logic [7:0] got,
   output var  logic       got_v
);
   initial begin
      serial_in_pin = 1'b1;
      got = 8'h00;
      got_v = 1'b0;
   end
   // A wrong parity bit goes out only when the bench asks for it; the line idles high after.
   task automatic send(input logic [7:0] d, input logic bad);
      logic [10:0] fr;
      fr = {1'b1, bad ^ ~parity_even ^ (^d), d, 1'b0};
      if (!parity_enable_bit) fr[9] = 1'b1;
      for (int i = 0; i < (parity_enable_bit ? 11 : 10); i++) begin
         serial_in_pin <= fr[i];
         repeat (BT) @(posedge core_clk);
      end
      repeat (BT) @(posedge core_clk);
   endtask
   // Skips to mid stop after the data so a low parity bit is not taken for a start.
   initial forever begin
      @(negedge serial_out_pin);
      repeat (BT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(posedge core_clk);
         got[i] = serial_out_pin;
      end
      got_v <= 1'b1;
      @(posedge core_clk);
      got_v <= 1'b0;
      repeat (BT * (1 + parity_enable_bit)) @(posedge core_clk);
   end
endmodule
`default_nettype wire

// [usf_uart.v]
// Serial port with status flags, data buffers and read-then-access clearing.
// What this block does
// - Set parity error when computed parity differs from received parity bit.
// - Clear parity error only on buffer read after a status read.
// - Set overrun when a full character arrives while buffer holds unread data.
// - On overrun discard the new character, keep the buffer contents.
// - Clear overrun on receive buffer read following a status read.
// - Keep reception disabled while the overrun flag is set.
// - Set receive-full when a character is loaded into the receive buffer.
// - Clear receive-full on receive buffer read after a status read.
// - Overrun set between status read and buffer read survives that buffer read.
// - Set buffer-empty when the buffer moves to the shift register and sending starts.
// - Clear buffer-empty on transmit buffer write after a status read.
// - Set transmit-end when a character is sent and the buffer is empty.
// - Clear transmit-end when a new transmission begins after a buffer write.
// - Status bits 7..2: parity, framing, overrun, rx full, tx done, tx empty; reset 0000 11.
// - Raise receive interrupt request when a character is loaded into the buffer.
// - Raise transmit interrupt request together with setting buffer-empty.
`timescale 1ns/1ps
`default_nettype none
`include "usf_consts.vh"
module usf_uart #(
   parameter DIV_W = 16
) (
   input  wire             core_clk,
   input  wire             srst,
   input  wire             clk_en,
   input  wire             rx_enable,
   input  wire             tx_enable,
   input  wire             parity_enable_bit,
   input  wire             parity_even,
   input  wire             two_stop_bits,
   input  wire [DIV_W-1:0] bit_period,
   input  wire             status_rd,
   input  wire             rx_buf_rd,
   input  wire             tx_buf_wr,
   input  wire [7:0]       tx_wdata,
   input  wire             serial_in_pin,
   output reg              serial_out_pin,
   output wire [7:0]       serial_status_reg,
   output reg  [7:0]       rx_data_buffer,
   output reg              rx_irq,
   output reg              tx_irq
);
   reg        parity_err_flag;
   reg        framing_err_flag;
   reg        overrun_reg;
   reg        rx_full_reg;
   reg        tx_done_flag;
   reg        tx_buf_empty_flag;
   reg [7:0]  snap_reg;
   reg [7:0]  tx_data_buffer;
   reg        tx_pend_reg;
   reg [1:0]  tx_state_reg;
   reg [7:0]  tx_shift_reg;
   reg [3:0]  tx_cnt_reg;
   reg        tx_par_reg;
   reg        tx_run_reg;
   reg [1:0]  rx_state_reg;
   reg [7:0]  rx_shift_reg;
   reg [3:0]  rx_cnt_reg;
   reg        rx_par_reg;
   reg        rx_run_reg;
   reg        rx_in_reg;
   wire       tx_tick;
   wire       rx_tick;
   wire       tx_start;
   wire       rx_done;
   wire       rx_load;
   wire       rx_overrun;
   wire       rx_par_bad;
   wire       clr_rx;
   wire       clr_tx;
   wire       tx_finish;
   wire [DIV_W-1:0] rx_half;
   wire [DIV_W-1:0] tx_first;

   // The start bit is driven one edge before the timer runs, so its first count is one short.
   assign tx_first = bit_period - {{(DIV_W-1){1'b0}}, 1'b1};
   assign rx_half  = {1'b0, bit_period[DIV_W-1:1]};

   assign serial_status_reg = {parity_err_flag, framing_err_flag, overrun_reg, rx_full_reg,
                               tx_done_flag, tx_buf_empty_flag, 2'b00};

   // A buffer access only counts as a clear once a status read has armed the snapshot.
   assign clr_rx = rx_buf_rd & snap_reg[0];
   assign clr_tx = tx_buf_wr & snap_reg[1];

   usf_bit_timer #(
      .DIV_W (DIV_W)
   ) u_tx_timer (
      .core_clk   (core_clk),
      .srst       (srst),
      .clk_en     (clk_en),
      .run        (tx_run_reg),
      .half_start (tx_first),
      .period     (bit_period),
      .tick       (tx_tick)
   );

   usf_bit_timer #(
      .DIV_W (DIV_W)
   ) u_rx_timer (
      .core_clk   (core_clk),
      .srst       (srst),
      .clk_en     (clk_en),
      .run        (rx_run_reg),
      .half_start (rx_half),
      .period     (bit_period),
      .tick       (rx_tick)
   );

   // Snapshot of flags at the last status read; bit 0/1 arm the rx/tx clears.
   always @(posedge core_clk) begin
      if (srst) begin
         snap_reg <= 8'h00;
      end else if (clk_en) begin
         if (status_rd) begin
            snap_reg <= {serial_status_reg[7:2], 2'b11};
         end else begin
            if (rx_buf_rd) begin
               snap_reg[0]   <= 1'b0;
               snap_reg[7:4] <= 4'h0;
            end
            if (tx_buf_wr) begin
               snap_reg[1]   <= 1'b0;
               snap_reg[3:2] <= 2'b00;
            end
         end
      end
   end

   // Transmit side.
   assign tx_start  = (tx_state_reg == `USF_TX_IDLE) & tx_pend_reg & tx_enable;
   assign tx_finish = (tx_state_reg == `USF_TX_STOP) & tx_tick & (tx_cnt_reg == 4'h0);

   always @(posedge core_clk) begin
      if (srst) begin
         tx_data_buffer    <= 8'h00;
         tx_pend_reg       <= 1'b0;
         tx_buf_empty_flag <= 1'b1;
         tx_done_flag      <= 1'b1;
         tx_state_reg      <= `USF_TX_IDLE;
         tx_shift_reg      <= 8'h00;
         tx_cnt_reg        <= 4'h0;
         tx_par_reg        <= 1'b0;
         tx_run_reg        <= 1'b0;
         serial_out_pin    <= 1'b1;
         tx_irq            <= 1'b0;
      end else if (clk_en) begin
         tx_irq <= 1'b0;
         // Without a prior status read the write is ignored and nothing is sent.
         if (clr_tx) begin
            tx_data_buffer    <= tx_wdata;
            tx_pend_reg       <= 1'b1;
            tx_buf_empty_flag <= 1'b0;
         end
         if (tx_start) begin
            tx_pend_reg       <= 1'b0;
            tx_buf_empty_flag <= 1'b1;
            tx_irq            <= 1'b1;
            tx_done_flag      <= 1'b0;
            tx_shift_reg      <= tx_data_buffer;
            tx_par_reg        <= ~parity_even;
            tx_cnt_reg        <= 4'h8;
            tx_run_reg        <= 1'b1;
            tx_state_reg      <= `USF_TX_SHIFT;
            serial_out_pin    <= 1'b0;
         end else if (tx_tick) begin
            case (tx_state_reg)
               `USF_TX_SHIFT: begin
                  if (tx_cnt_reg != 4'h0) begin
                     serial_out_pin <= tx_shift_reg[0];
                     tx_par_reg     <= tx_par_reg ^ tx_shift_reg[0];
                     tx_shift_reg   <= {1'b0, tx_shift_reg[7:1]};
                     tx_cnt_reg     <= tx_cnt_reg - 4'h1;
                  end else begin
                     serial_out_pin <= parity_enable_bit ? tx_par_reg : 1'b1;
                     tx_cnt_reg     <= parity_enable_bit ? (two_stop_bits ? 4'h2 : 4'h1)
                                                         : (two_stop_bits ? 4'h1 : 4'h0);
                     tx_state_reg   <= `USF_TX_STOP;
                  end
               end
               `USF_TX_STOP: begin
                  serial_out_pin <= 1'b1;
                  if (tx_finish) begin
                     tx_run_reg   <= 1'b0;
                     tx_state_reg <= `USF_TX_IDLE;
                     if (!tx_pend_reg) begin
                        tx_done_flag <= 1'b1;
                     end
                  end else begin
                     tx_cnt_reg <= tx_cnt_reg - 4'h1;
                  end
               end
               default: begin
                  tx_state_reg <= `USF_TX_IDLE;
               end
            endcase
         end
      end
   end

   // Receive side.
   assign rx_done    = (rx_state_reg == `USF_RX_STOP) & rx_tick;
   // A good frame leaves the running XOR of data and parity at 0 for even parity, 1 for odd.
   assign rx_par_bad = parity_enable_bit & (rx_par_reg == parity_even);
   assign rx_overrun = rx_done & rx_full_reg & ~clr_rx;
   assign rx_load    = rx_done & ~rx_overrun;

   always @(posedge core_clk) begin
      if (srst) begin
         rx_in_reg    <= 1'b1;
         rx_state_reg <= `USF_RX_IDLE;
         rx_shift_reg <= 8'h00;
         rx_cnt_reg   <= 4'h0;
         rx_par_reg   <= 1'b0;
         rx_run_reg   <= 1'b0;
      end else if (clk_en) begin
         rx_in_reg <= serial_in_pin;
         case (rx_state_reg)
            `USF_RX_IDLE: begin
               // Start bit is accepted only with no overrun pending.
               if (rx_enable & ~overrun_reg & ~rx_in_reg) begin
                  rx_run_reg   <= 1'b1;
                  rx_cnt_reg   <= 4'h9;
                  rx_par_reg   <= 1'b0;
                  rx_state_reg <= `USF_RX_DATA;
               end
            end
            `USF_RX_DATA: begin
               if (rx_tick) begin
                  if (rx_cnt_reg == 4'h9) begin
                     rx_cnt_reg <= 4'h8;
                  end else begin
                     rx_shift_reg <= {rx_in_reg, rx_shift_reg[7:1]};
                     rx_par_reg   <= rx_par_reg ^ rx_in_reg;
                     rx_cnt_reg   <= rx_cnt_reg - 4'h1;
                     if (rx_cnt_reg == 4'h1) begin
                        rx_state_reg <= parity_enable_bit ? `USF_RX_PAR : `USF_RX_STOP;
                     end
                  end
               end
            end
            `USF_RX_PAR: begin
               if (rx_tick) begin
                  rx_par_reg   <= rx_par_reg ^ rx_in_reg;
                  rx_state_reg <= `USF_RX_STOP;
               end
            end
            `USF_RX_STOP: begin
               if (rx_tick) begin
                  rx_run_reg   <= 1'b0;
                  rx_state_reg <= `USF_RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= `USF_RX_IDLE;
            end
         endcase
      end
   end

   // Receive flags: a set in the same cycle as a clear wins.
   always @(posedge core_clk) begin
      if (srst) begin
         rx_data_buffer   <= 8'h00;
         rx_full_reg      <= 1'b0;
         overrun_reg      <= 1'b0;
         parity_err_flag  <= 1'b0;
         framing_err_flag <= 1'b0;
         rx_irq           <= 1'b0;
      end else if (clk_en) begin
         rx_irq <= 1'b0;
         if (rx_load) begin
            rx_data_buffer <= rx_shift_reg;
            rx_full_reg    <= 1'b1;
            rx_irq         <= 1'b1;
         end else if (clr_rx & snap_reg[`USF_SR_RX_FULL_BIT]) begin
            rx_full_reg <= 1'b0;
         end
         if (rx_overrun) begin
            overrun_reg <= 1'b1;
         end else if (clr_rx & snap_reg[`USF_SR_OVR_ERR_BIT]) begin
            overrun_reg <= 1'b0;
         end
         if (rx_load & rx_par_bad) begin
            parity_err_flag <= 1'b1;
         end else if (clr_rx & snap_reg[`USF_SR_PAR_ERR_BIT]) begin
            parity_err_flag <= 1'b0;
         end
         if (rx_load & ~rx_in_reg) begin
            framing_err_flag <= 1'b1;
         end else if (clr_rx & snap_reg[`USF_SR_FRM_ERR_BIT]) begin
            framing_err_flag <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [usf_uart_chk.sv]
// Concurrent checks on the status flags, interrupt pulses and line of the serial port.
`timescale 1ns/1ps
`default_nettype none
module usf_uart_chk #(
   parameter DIV_W = 16
) (
   input wire logic             core_clk,
   input wire logic             srst,
   input wire logic             clk_en,
   input wire logic             rx_enable,
   input wire logic             tx_enable,
   input wire logic             parity_enable_bit,
   input wire logic             parity_even,
   input wire logic             two_stop_bits,
   input wire logic [DIV_W-1:0] bit_period,
   input wire logic             status_rd,
   input wire logic             rx_buf_rd,
   input wire logic             tx_buf_wr,
   input wire logic [7:0]       tx_wdata,
   input wire logic             serial_in_pin,
   input wire logic             serial_out_pin,
   input wire logic [7:0]       serial_status_reg,
   input wire logic [7:0]       rx_data_buffer,
   input wire logic             rx_irq,
   input wire logic             tx_irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire [7:0] s = serial_status_reg;
   property p_rst; $fell(srst) |-> s == 8'h0C && s[1:0] == 2'h0; endproperty
   a_rst: assert property (p_rst) else $error("status after reset");
   property p_par_clr; $fell(s[7]) |-> $past(rx_buf_rd); endproperty
   a_par_clr: assert property (p_par_clr) else $error("parity flag cleared without read");
   property p_oe_clr; $fell(s[5]) |-> $past(rx_buf_rd); endproperty
   a_oe_clr: assert property (p_oe_clr) else $error("overrun cleared without read");
   property p_rf_clr; $fell(s[4]) |-> $past(rx_buf_rd); endproperty
   a_rf_clr: assert property (p_rf_clr) else $error("full cleared without read");
   property p_tb_clr; $fell(s[2]) |-> $past(tx_buf_wr); endproperty
   a_tb_clr: assert property (p_tb_clr) else $error("empty cleared without write");
   property p_ovr; $rose(s[5]) |-> $stable(rx_data_buffer) && !rx_irq; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun touched buffer");
   property p_load; $rose(s[4]) |-> rx_irq ##1 !rx_irq; endproperty
   a_load: assert property (p_load) else $error("load without single pulse");
   property p_irq; rx_irq |-> s[4] && !s[5]; endproperty
   a_irq: assert property (p_irq) else $error("load while overrun");
   property p_start; tx_irq |-> s[2] && !s[3] && !serial_out_pin; endproperty
   a_start: assert property (p_start) else $error("transmit start flags");
   property p_end; $rose(s[3]) |-> s[2] && serial_out_pin; endproperty
   a_end: assert property (p_end) else $error("end with data pending");
   property p_end_clr; $fell(s[3]) |-> tx_irq; endproperty
   a_end_clr: assert property (p_end_clr) else $error("end cleared without start");
   property p_par; $rose(s[7]) |-> parity_enable_bit; endproperty
   a_par: assert property (p_par) else $error("parity flag with parity off");
   c_ovr: cover property ($rose(s[5]));
   c_par: cover property ($rose(s[7]));
   c_end: cover property ($rose(s[3]));
endmodule
bind usf_uart usf_uart_chk #(.DIV_W(DIV_W)) u_chk (.*);
`default_nettype wire
